// File: core/prfs_apb_front.sv
/*
 * APB slave front end: zero-wait handshake, word alignment check and
 * error answer for unmapped addresses.
 * Assumes the register file answers hit and rdata combinationally.
 */
`timescale 1ns/1ps
module prfs_apb_front
    import prfs_pkg::*;
(
    input wire logic psel, // Slave select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write when high
    input wire logic [PRFS_ADDR_W-1:0] paddr, // Byte address
    input wire logic [31:0] pwdata, // Write data
    output logic [31:0] prdata, // Read data
    output logic pready, // Always ready
    output logic pslverr, // Unmapped or misaligned
    prfs_bus_if.front bus // Decoded access
);
    logic access;
    logic aligned;

    assign access = psel & penable;
    assign aligned = (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign bus.wr_en = access & pwrite & aligned;
    assign bus.rd_en = access & ~pwrite & aligned;
    assign bus.index = paddr[PRFS_ADDR_W-1:2];
    assign bus.wdata = pwdata;
    assign prdata = (bus.rd_en & bus.hit) ? bus.rdata : 32'h00000000;
    assign pslverr = access & ~(aligned & bus.hit);
endmodule

// File: core/prfs_bus_if.sv
/*
 * Decoded register access passed from the APB front end to the
 * register file of the pin function selector.
 * Assumes one access per cycle, answered in the same cycle.
 */
`timescale 1ns/1ps
interface prfs_bus_if;
    import prfs_pkg::*;
    logic wr_en;
    logic rd_en;
    logic [PRFS_IDX_W-1:0] index;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic hit;

    modport front (output wr_en, output rd_en, output index, output wdata,
                   input rdata, input hit);
    modport regs (input wr_en, input rd_en, input index, input wdata,
                  output rdata, output hit);
endinterface

// File: core/prfs_pin_cell.sv
/*
 * One R port pin: chooses between port role and shared peripheral
 * role and forms the output value and output enable.
 * Assumes the pad merges output and enable into the wire level.
 */
`timescale 1ns/1ps
module prfs_pin_cell #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic direction, // Data-control bit
    input wire logic latch, // Output latch bit
    input wire logic periph_sel, // Peripheral role chosen
    input wire logic periph_drive, // Peripheral drives the pin
    input wire logic periph_out, // Peripheral output value
    output logic pin_o, // Pad output value
    output logic pin_oe // Pad output enable
);
    always_comb begin
        if (periph_sel) begin
            pin_o = periph_out;
            pin_oe = periph_drive;
        end else if (OPEN_DRAIN) begin
            pin_o = 1'b0;
            pin_oe = direction & ~latch;
        end else begin
            pin_o = latch;
            pin_oe = direction;
        end
    end
endmodule

// File: core/prfs_pkg.sv
/*
 * Constants for the R port pin function selector: register indexes,
 * field positions, widths and reset values.
 * Assumes APB with 32-bit data; byte address is four times the index.
 */
package prfs_pkg;
    localparam int PRFS_NUM_PORTS = 6;
    localparam int PRFS_PORT_W = 4;
    localparam int PRFS_NUM_PINS = PRFS_NUM_PORTS * PRFS_PORT_W;
    localparam int PRFS_ADDR_W = 12;
    localparam int PRFS_IDX_W = 10;

    // Register indexes (byte address = index * 4)
    localparam logic [9:0] PRFS_IDX_PORT_FUNCTION_MODE = 10'h004;
    localparam logic [9:0] PRFS_IDX_SERIAL_MODE_CONTROL = 10'h005;
    localparam logic [9:0] PRFS_IDX_ANALOG_SELECT_LOW = 10'h019;
    localparam logic [9:0] PRFS_IDX_ANALOG_SELECT_HIGH = 10'h01A;
    localparam logic [9:0] PRFS_IDX_DIRECTION_BASE = 10'h030;
    localparam logic [9:0] PRFS_IDX_OUTPUT_LATCH_BASE = 10'h040;
    localparam logic [9:0] PRFS_IDX_PIN_LEVEL_BASE = 10'h048;

    // Field positions
    localparam int PRFS_BIT_SERIAL_OUT_SELECT = 0;
    localparam int PRFS_BIT_SERIAL_IN_SELECT = 1;
    localparam int PRFS_BIT_TIMER_OUT_SELECT = 2;
    localparam int PRFS_BIT_SERIAL_CLOCK_SELECT = 3;
    localparam int PRFS_BIT_ADC_MODE = 0;
    localparam int PRFS_BIT_PORT4_ANALOG_ENABLE = 1;
    localparam int PRFS_BIT_PORT5_ANALOG_ENABLE = 2;

    // Pin numbers inside the flat 24-pin vector
    localparam int PRFS_PIN_SCK = 0;
    localparam int PRFS_PIN_SI = 1;
    localparam int PRFS_PIN_SO = 2;
    localparam int PRFS_PIN_TOC = 3;
    localparam int PRFS_PIN_PORT3 = 12;
    localparam int PRFS_PIN_PORT4 = 16;
    localparam int PRFS_PIN_PORT5 = 20;

    // Reset values
    localparam logic [3:0] PRFS_RST_MODE4 = 4'h0;
    localparam logic [2:0] PRFS_RST_MODE3 = 3'h0;
    localparam logic [23:0] PRFS_RST_DIRECTION = 24'h000000;
    localparam logic [23:0] PRFS_RST_OUTPUT_LATCH = 24'hFFFFFF;
    localparam logic [23:0] PRFS_RST_PIN_LEVEL = 24'h000000;
    localparam logic PRFS_RST_SERIAL_IDLE = 1'b1;
endpackage

// File: core/prfs_port_r_function_select.sv
/*
 * R port pin function selector for ports R0 to R5: mode registers,
 * data-control and output latch registers, pin mux and APB access.
 * Assumes APB master on CLK_SYS; pins and peripheral signals are
 * synchronous to CLK_SYS.
 */
`timescale 1ns/1ps
module prfs_port_r_function_select
    import prfs_pkg::*;
(
    input wire logic CLK_SYS, // System clock
    input wire logic ARST_N, // Asynchronous reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [PRFS_ADDR_W-1:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic STOP_MODE, // Stop mode entry level
    input wire logic TIMER_C_OUTPUT, // Timer C output value
    input wire logic SER_TX_DATA, // Serial transmit data
    input wire logic SER_CLK_OUT, // Serial clock driven value
    input wire logic SER_CLK_OE, // Serial clock drive enable
    output logic SER_RX_DATA, // Serial receive data
    output logic SER_CLK_IN, // Serial clock seen on pin
    output logic [2:0] SER_MODE, // Serial mode low bits
    output logic ADC_MODE, // Converter mode bit
    output logic [11:0] ANALOG_CHANNEL_SEL, // Analog channel pins
    input wire logic [PRFS_NUM_PINS-1:0] PIN_I, // Pin levels
    output logic [PRFS_NUM_PINS-1:0] PIN_O, // Pin output values
    output logic [PRFS_NUM_PINS-1:0] PIN_OE // Pin output enables
);
    logic [3:0] port_function_mode_reg;
    logic [3:0] serial_mode_control_reg;
    logic [3:0] analog_select_low_reg;
    logic [2:0] analog_select_high_reg;
    logic [PRFS_NUM_PINS-1:0] direction_reg;
    logic [PRFS_NUM_PINS-1:0] output_latch_reg;
    logic [PRFS_NUM_PINS-1:0] pin_level_reg;
    logic ser_rx_reg;
    logic ser_clk_in_reg;
    logic [PRFS_NUM_PINS-1:0] periph_sel;
    logic [PRFS_NUM_PINS-1:0] periph_drive;
    logic [PRFS_NUM_PINS-1:0] periph_out;
    logic timer_out_select;
    logic serial_in_select;
    logic serial_out_select;
    logic serial_clock_select;
    logic port4_analog_enable;
    logic port5_analog_enable;

    prfs_bus_if bus ();

    prfs_apb_front u_front (
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .pwdata(PWDATA),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .bus(bus.front)
    );

    assign timer_out_select = port_function_mode_reg[PRFS_BIT_TIMER_OUT_SELECT];
    assign serial_in_select = port_function_mode_reg[PRFS_BIT_SERIAL_IN_SELECT];
    assign serial_out_select = port_function_mode_reg[PRFS_BIT_SERIAL_OUT_SELECT];
    assign serial_clock_select = serial_mode_control_reg[PRFS_BIT_SERIAL_CLOCK_SELECT];
    assign port4_analog_enable = analog_select_high_reg[PRFS_BIT_PORT4_ANALOG_ENABLE];
    assign port5_analog_enable = analog_select_high_reg[PRFS_BIT_PORT5_ANALOG_ENABLE];

    // Mode registers
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            port_function_mode_reg <= PRFS_RST_MODE4;
            serial_mode_control_reg <= PRFS_RST_MODE4;
            analog_select_low_reg <= PRFS_RST_MODE4;
            analog_select_high_reg <= PRFS_RST_MODE3;
        end else if (bus.wr_en) begin
            if (bus.index == PRFS_IDX_PORT_FUNCTION_MODE) begin
                port_function_mode_reg <= bus.wdata[3:0];
            end else if (bus.index == PRFS_IDX_SERIAL_MODE_CONTROL) begin
                serial_mode_control_reg <= bus.wdata[3:0];
            end else if (bus.index == PRFS_IDX_ANALOG_SELECT_LOW) begin
                analog_select_low_reg <= bus.wdata[3:0];
            end else if (bus.index == PRFS_IDX_ANALOG_SELECT_HIGH) begin
                analog_select_high_reg <= bus.wdata[2:0];
            end
        end
    end

    // Data-control bits, one word per port
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            direction_reg <= PRFS_RST_DIRECTION;
        end else if (bus.wr_en) begin
            for (int k = 0; k < PRFS_NUM_PORTS; k++) begin
                if (bus.index == PRFS_IDX_DIRECTION_BASE + 10'(k)) begin
                    direction_reg[k*PRFS_PORT_W +: PRFS_PORT_W] <= bus.wdata[3:0];
                end
            end
        end
    end

    // Output latches; stop mode forces ones over any write
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            output_latch_reg <= PRFS_RST_OUTPUT_LATCH;
        end else if (STOP_MODE) begin
            output_latch_reg <= PRFS_RST_OUTPUT_LATCH;
        end else if (bus.wr_en) begin
            for (int k = 0; k < PRFS_NUM_PORTS; k++) begin
                if (bus.index == PRFS_IDX_OUTPUT_LATCH_BASE + 10'(k)) begin
                    output_latch_reg[k*PRFS_PORT_W +: PRFS_PORT_W] <= bus.wdata[3:0];
                end
            end
        end
    end

    // Pin level capture and serial inputs
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_level_reg <= PRFS_RST_PIN_LEVEL;
            ser_rx_reg <= PRFS_RST_SERIAL_IDLE;
            ser_clk_in_reg <= PRFS_RST_SERIAL_IDLE;
        end else begin
            pin_level_reg <= PIN_I;
            ser_rx_reg <= serial_in_select ? PIN_I[PRFS_PIN_SI] : PRFS_RST_SERIAL_IDLE;
            ser_clk_in_reg <= serial_clock_select ? PIN_I[PRFS_PIN_SCK]
                                                  : PRFS_RST_SERIAL_IDLE;
        end
    end

    assign SER_RX_DATA = ser_rx_reg;
    assign SER_CLK_IN = ser_clk_in_reg;
    assign SER_MODE = serial_mode_control_reg[2:0];
    assign ADC_MODE = analog_select_high_reg[PRFS_BIT_ADC_MODE];
    assign ANALOG_CHANNEL_SEL = {{4{port5_analog_enable}}, {4{port4_analog_enable}},
                                 analog_select_low_reg};

    // Peripheral role per pin
    always_comb begin
        periph_sel = '0;
        periph_drive = '0;
        periph_out = '0;
        periph_sel[PRFS_PIN_SCK] = serial_clock_select;
        periph_drive[PRFS_PIN_SCK] = SER_CLK_OE;
        periph_out[PRFS_PIN_SCK] = SER_CLK_OUT;
        periph_sel[PRFS_PIN_SI] = serial_in_select;
        periph_sel[PRFS_PIN_SO] = serial_out_select;
        periph_drive[PRFS_PIN_SO] = 1'b1;
        periph_out[PRFS_PIN_SO] = SER_TX_DATA;
        periph_sel[PRFS_PIN_TOC] = timer_out_select;
        periph_drive[PRFS_PIN_TOC] = 1'b1;
        periph_out[PRFS_PIN_TOC] = TIMER_C_OUTPUT;
        periph_sel[PRFS_PIN_PORT3 +: 4] = analog_select_low_reg;
        periph_sel[PRFS_PIN_PORT4 +: 4] = {4{port4_analog_enable}};
        periph_sel[PRFS_PIN_PORT5 +: 4] = {4{port5_analog_enable}};
    end

    // One cell per pin; R1 and R2 are open drain
    for (genvar i = 0; i < PRFS_NUM_PINS; i++) begin : g_pin
        prfs_pin_cell #(
            .OPEN_DRAIN((i >= 4) && (i < 12))
        ) u_cell (
            .direction(direction_reg[i]),
            .latch(output_latch_reg[i]),
            .periph_sel(periph_sel[i]),
            .periph_drive(periph_drive[i]),
            .periph_out(periph_out[i]),
            .pin_o(PIN_O[i]),
            .pin_oe(PIN_OE[i])
        );
    end

    // Read decode; write-only registers answer zero
    always_comb begin
        bus.rdata = 32'h00000000;
        bus.hit = 1'b0;
        if (bus.index == PRFS_IDX_PORT_FUNCTION_MODE) begin
            bus.hit = 1'b1;
        end else if (bus.index == PRFS_IDX_SERIAL_MODE_CONTROL) begin
            bus.hit = 1'b1;
        end else if (bus.index == PRFS_IDX_ANALOG_SELECT_LOW) begin
            bus.hit = 1'b1;
        end else if (bus.index == PRFS_IDX_ANALOG_SELECT_HIGH) begin
            bus.hit = 1'b1;
        end else if (bus.index >= PRFS_IDX_DIRECTION_BASE &&
                     bus.index < PRFS_IDX_DIRECTION_BASE + 10'(PRFS_NUM_PORTS)) begin
            bus.hit = 1'b1;
        end else if (bus.index >= PRFS_IDX_OUTPUT_LATCH_BASE &&
                     bus.index < PRFS_IDX_OUTPUT_LATCH_BASE + 10'(PRFS_NUM_PORTS)) begin
            bus.hit = 1'b1;
        end else if (bus.index >= PRFS_IDX_PIN_LEVEL_BASE &&
                     bus.index < PRFS_IDX_PIN_LEVEL_BASE + 10'(PRFS_NUM_PORTS)) begin
            bus.hit = 1'b1;
            for (int k = 0; k < PRFS_NUM_PORTS; k++) begin
                if (bus.index == PRFS_IDX_PIN_LEVEL_BASE + 10'(k)) begin
                    bus.rdata[3:0] = pin_level_reg[k*PRFS_PORT_W +: PRFS_PORT_W];
                end
            end
        end
    end
endmodule

// File: tb/prfs_assertions.sv
/*
 * Concurrent checks on the pin function selector top ports.
 * Assumes one clock domain, CLK_SYS, with ARST_N active low.
 */
`timescale 1ns/1ps
module prfs_assertions
    import prfs_pkg::*;
(
    input wire logic CLK_SYS, // System clock
    input wire logic ARST_N, // Reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic STOP_MODE, // Stop mode level
    input wire logic SER_RX_DATA, // Serial receive data
    input wire logic SER_CLK_IN, // Serial clock seen
    input wire logic [2:0] SER_MODE, // Serial mode bits
    input wire logic [11:0] ANALOG_CHANNEL_SEL, // Analog pins
    input wire logic [PRFS_NUM_PINS-1:0] PIN_I, // Pin levels
    input wire logic [PRFS_NUM_PINS-1:0] PIN_O, // Pin values
    input wire logic [PRFS_NUM_PINS-1:0] PIN_OE // Pin enables
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);

    a_od_never_high: assert property (PIN_O[11:4] == 8'h00)
        else $error("open drain pin drives high");
    a_stop_od_off: assert property ($past(STOP_MODE) |-> PIN_OE[11:4] == 8'h00)
        else $error("open drain pin drives low after stop");
    a_r3_analog_off: assert property ((PIN_OE[15:12] & ANALOG_CHANNEL_SEL[3:0]) == 4'h0)
        else $error("analog R3 pin driven");
    a_r4_analog_off: assert property ((PIN_OE[19:16] & ANALOG_CHANNEL_SEL[7:4]) == 4'h0)
        else $error("analog R4 pin driven");
    a_r5_analog_off: assert property ((PIN_OE[23:20] & ANALOG_CHANNEL_SEL[11:8]) == 4'h0)
        else $error("analog R5 pin driven");
    a_smode_by_write: assert property ($changed(SER_MODE) |->
        $past(PSEL && PENABLE && PWRITE))
        else $error("serial mode changed without write");
    a_amode_by_write: assert property ($changed(ANALOG_CHANNEL_SEL) |->
        $past(PSEL && PENABLE && PWRITE))
        else $error("analog select changed without write");
    a_rx_tracks_pin: assert property (!SER_RX_DATA |-> !$past(PIN_I[1]))
        else $error("receive data low without low pin");
    a_sck_tracks_pin: assert property (!SER_CLK_IN |-> !$past(PIN_I[0]))
        else $error("serial clock low without low pin");
endmodule

bind prfs_port_r_function_select prfs_assertions u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .STOP_MODE(STOP_MODE),
    .SER_RX_DATA(SER_RX_DATA), .SER_CLK_IN(SER_CLK_IN), .SER_MODE(SER_MODE),
    .ANALOG_CHANNEL_SEL(ANALOG_CHANNEL_SEL), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE));

// File: tb/prfs_port_r_function_select_test.sv
/*
 * Self-checking bench for the pin function selector over APB.
 * Assumes the zero-wait slave and the pin behaviour of the hand-over.
 */
`timescale 1ns/1ps
module prfs_port_r_function_select_test;
    import prfs_pkg::*;
    logic CLK_SYS = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, STOP_MODE = 0;
    logic TIMER_C_OUTPUT = 0, SER_TX_DATA = 0, SER_CLK_OUT = 0, SER_CLK_OE = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, SER_RX_DATA, SER_CLK_IN, ADC_MODE, er;
    logic [2:0] SER_MODE, ash;
    logic [11:0] ANALOG_CHANNEL_SEL;
    logic [23:0] PIN_I = 24'hFFFFFF, PIN_O, PIN_OE, dir, lat;
    logic [3:0] pfm, smc, asl;
    int fail_count = 0, compares = 0;

    always #2.5 CLK_SYS = ~CLK_SYS;

    prfs_port_r_function_select uut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .STOP_MODE(STOP_MODE),
        .TIMER_C_OUTPUT(TIMER_C_OUTPUT), .SER_TX_DATA(SER_TX_DATA), .SER_CLK_OUT(SER_CLK_OUT),
        .SER_CLK_OE(SER_CLK_OE), .SER_RX_DATA(SER_RX_DATA), .SER_CLK_IN(SER_CLK_IN),
        .SER_MODE(SER_MODE), .ADC_MODE(ADC_MODE), .ANALOG_CHANNEL_SEL(ANALOG_CHANNEL_SEL),
        .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE));

    task finish_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask

    // Write a register and keep the bench's own copy of it
    task wr(input logic [9:0] i, input logic [3:0] d);
        int k;
        apb(1'b1, {i, 2'b00}, {28'h0, d});
        chk("write_err", 32'h0, {31'h0, er});
        if (i == PRFS_IDX_PORT_FUNCTION_MODE) pfm = d;
        if (i == PRFS_IDX_SERIAL_MODE_CONTROL) smc = d;
        if (i == PRFS_IDX_ANALOG_SELECT_LOW) asl = d;
        if (i == PRFS_IDX_ANALOG_SELECT_HIGH) ash = d[2:0];
        k = int'(i) - int'(PRFS_IDX_DIRECTION_BASE);
        if (k >= 0 && k < 6) dir[k*4 +: 4] = d;
        k = int'(i) - int'(PRFS_IDX_OUTPUT_LATCH_BASE);
        if (k >= 0 && k < 6) lat[k*4 +: 4] = d;
    endtask

    task check_pins;
        logic [23:0] oe, o;
        logic [15:0] md, ms;
        @(negedge CLK_SYS);
        o = lat;
        oe = dir;
        o[11:4] = 8'h00;
        oe[11:4] = dir[11:4] & ~lat[11:4];
        if (smc[3]) begin
            o[0] = SER_CLK_OUT;
            oe[0] = SER_CLK_OE;
        end
        if (pfm[1]) oe[1] = 1'b0;
        if (pfm[0]) begin
            o[2] = SER_TX_DATA;
            oe[2] = 1'b1;
        end
        if (pfm[2]) begin
            o[3] = TIMER_C_OUTPUT;
            oe[3] = 1'b1;
        end
        oe[15:12] = oe[15:12] & ~asl;
        if (ash[1]) oe[19:16] = 4'h0;
        if (ash[2]) oe[23:20] = 4'h0;
        md = {smc[2:0], ash[0], {4{ash[2]}}, {4{ash[1]}}, asl};
        ms = {SER_MODE, ADC_MODE, ANALOG_CHANNEL_SEL};
        chk("pin_oe", {8'h0, oe}, {8'h0, PIN_OE});
        chk("pin_o", {8'h0, o & oe}, {8'h0, PIN_O & oe});
        chk("modes", {16'h0, md}, {16'h0, ms});
    endtask

    initial begin
        pfm = 4'h0;
        smc = 4'h0;
        asl = 4'h0;
        ash = 3'h0;
        dir = 24'h000000;
        lat = 24'hFFFFFF;
        repeat (5) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        check_pins();
        chk("serial_in_idle", 32'h3, {30'h0, SER_RX_DATA, SER_CLK_IN});
        for (int v = 0; v < 3; v++) begin
            for (int r = 0; r < 6; r++) begin
                wr(PRFS_IDX_DIRECTION_BASE + 10'(r), 4'(15 >> v));
                wr(PRFS_IDX_OUTPUT_LATCH_BASE + 10'(r), 4'(5 << v));
            end
            check_pins();
        end
        for (int r = 0; r < 6; r++) wr(PRFS_IDX_DIRECTION_BASE + 10'(r), 4'hF);
        for (int v = 0; v < 2; v++) begin
            @(posedge CLK_SYS);
            TIMER_C_OUTPUT <= v[0];
            SER_TX_DATA <= ~v[0];
            SER_CLK_OUT <= v[0];
            SER_CLK_OE <= v[0];
            wr(PRFS_IDX_PORT_FUNCTION_MODE, 4'h7);
            wr(PRFS_IDX_SERIAL_MODE_CONTROL, v ? 4'hD : 4'h2);
            check_pins();
        end
        @(posedge CLK_SYS);
        PIN_I[1:0] <= 2'b00;
        repeat (2) @(posedge CLK_SYS);
        check_pins();
        chk("serial_in", 32'h0, {30'h0, SER_RX_DATA, SER_CLK_IN});
        apb(1'b0, {PRFS_IDX_PIN_LEVEL_BASE, 2'b00}, 32'h0);
        chk("pin_level", 32'hC, rd);
        wr(PRFS_IDX_PORT_FUNCTION_MODE, 4'h0);
        wr(PRFS_IDX_SERIAL_MODE_CONTROL, 4'h0);
        // Serial clock input register still holds the pin for one more edge
        @(posedge CLK_SYS);
        check_pins();
        chk("serial_in_off", 32'h3, {30'h0, SER_RX_DATA, SER_CLK_IN});
        for (int v = 0; v < 4; v++) begin
            wr(PRFS_IDX_ANALOG_SELECT_LOW, 4'(1 << v));
            wr(PRFS_IDX_ANALOG_SELECT_HIGH, 4'(v * 2 + v % 2));
            check_pins();
        end
        apb(1'b0, {PRFS_IDX_SERIAL_MODE_CONTROL, 2'b00}, 32'h0);
        chk("wo_read", 32'h0, {rd[31:1], er});
        apb(1'b1, 12'hFFC, 32'hF);
        chk("unmapped_err", 32'h1, {31'h0, er});
        apb(1'b1, {PRFS_IDX_PORT_FUNCTION_MODE, 2'b10}, 32'hF);
        chk("misalign_err", 32'h1, {31'h0, er});
        check_pins();
        for (int r = 0; r < 6; r++) wr(PRFS_IDX_OUTPUT_LATCH_BASE + 10'(r), 4'h0);
        check_pins();
        @(posedge CLK_SYS);
        STOP_MODE <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        STOP_MODE <= 1'b0;
        lat = 24'hFFFFFF;
        check_pins();
        for (int r = 0; r < 6; r++) wr(PRFS_IDX_OUTPUT_LATCH_BASE + 10'(r), 4'h0);
        @(posedge CLK_SYS);
        ARST_N <= 1'b0;
        {pfm, smc, asl, ash, dir, lat} = {15'h0, 24'h0, 24'hFFFFFF};
        check_pins();
        finish_test();
    end
endmodule
